// *** rtl/cxu_pkg.sv ***
// package: exception codes, status-word fields and register offsets
`default_nettype none
package cxu_pkg;
   // exception type codes
   localparam logic [1:0] CXU_ET_NORMAL = 2'h3;
   localparam logic [1:0] CXU_ET_STACK = 2'h2;
   localparam logic [1:0] CXU_ET_PROCESS = 2'h1;
   localparam logic [1:0] CXU_ET_RESET = 2'h0;
   // status word field positions
   localparam int CXU_PSW_C = 18;
   localparam int CXU_PSW_V = 19;
   localparam int CXU_PSW_Z = 20;
   localparam int CXU_PSW_N = 21;
   localparam int CXU_PSW_X = 26;
   localparam int CXU_PSW_AR = 27;
   localparam int CXU_PSW_EXUC = 28;
   localparam int CXU_PSW_EA = 29;
   localparam int CXU_PSW_RSV = 1;
   localparam logic [31:0] CXU_PSW_RESET = 32'h0000_0000;
   localparam logic [31:0] CXU_PSW_WMASK = 32'h3fff_ffff;
   localparam logic [31:0] CXU_FLAG_MASK = 32'h043c_0000;
   // register byte offsets
   localparam logic [7:0] CXU_A_PSW = 8'h00;
   localparam logic [7:0] CXU_A_CBP = 8'h04;
   localparam logic [7:0] CXU_A_COND = 8'h08;
   localparam logic [7:0] CXU_A_EXC = 8'h0c;
   localparam logic [7:0] CXU_A_ACCESS = 8'h10;
   localparam logic [7:0] CXU_A_SEQ = 8'h14;
   localparam logic [7:0] CXU_A_CMD = 8'h18;
   localparam logic [7:0] CXU_A_PREDEF = 8'h1c;
   // condition numbers written to the condition register
   typedef enum logic [4:0] {
      CXU_N_GATE_VEC, CXU_N_ILL_LEVEL, CXU_N_BKPT, CXU_N_PRIV_OP, CXU_N_ILL_OP,
      CXU_N_RSV_OP, CXU_N_INV_DESC, CXU_N_RSV_DT, CXU_N_PRIV_REG, CXU_N_ZDIV,
      CXU_N_EXT_MEM, CXU_N_TRACE, CXU_N_OVF, CXU_S_BOUND, CXU_S_FAULT, CXU_S_IID,
      CXU_P_OLD, CXU_P_GATE, CXU_P_NEW, CXU_R_OLD, CXU_R_SYSDATA, CXU_R_ISTK,
      CXU_R_EXT, CXU_R_NEW, CXU_R_GATE_VEC, CXU_N_ALIGN, CXU_N_NONE
   } cxu_cond_t;
   // switch sequence kinds
   localparam logic [1:0] CXU_SEQ_IDLE = 2'h0;
   localparam logic [1:0] CXU_SEQ_GATE = 2'h1;
   localparam logic [1:0] CXU_SEQ_SWITCH = 2'h2;
   localparam logic [1:0] CXU_SEQ_RESTART = 2'h3;
   // command register codes
   localparam logic [2:0] CXU_CMD_UCALL = 3'h1;
   localparam logic [2:0] CXU_CMD_RET = 3'h2;
   localparam logic [2:0] CXU_CMD_RESTART = 3'h3;
   localparam logic [2:0] CXU_CMD_BMOVE = 3'h4;
   localparam logic [2:0] CXU_CMD_BMNULL = 3'h5;
   // context block byte offsets
   localparam logic [31:0] CXU_PCB_INIT = 32'h0000_0000;
   localparam logic [31:0] CXU_PCB_SAVE = 32'h0000_000c;
   localparam logic [31:0] CXU_PCB_BOUNDS = 32'h0000_0018;
   localparam logic [31:0] CXU_PCB_GREGS = 32'h0000_0020;
   localparam logic [31:0] CXU_PCB_BMOVE = 32'h0000_0064;
   localparam logic [31:0] CXU_PREDEF_CBP = 32'h0000_0000;
endpackage
`default_nettype wire

// *** rtl/cxu_core.sv ***
// exception classifier, status word and context switch sequencer
`default_nettype none
// Operation
// (RULE_01) normal exceptions: type 11, ranks 1,3,4,5,6,7 for gate..reserved opcode
// (RULE_02) other normal exceptions: ranks 8,9,10,11,13,14,15, each own state code; ranks 8 and 13 both give code 5 here
// (RULE_03) stack exceptions: type 10, bound 0, fault 1, id fetch 3
// (RULE_04) process exceptions: type 01, old 0, gate 1, new 4
// (RULE_05) reset exceptions: type 00, ranks and codes 0,1,2,3,4,6
// (RULE_06) invalid descriptor, reserved data type, zero-divide clear condition flags
// (RULE_07) option bit 28 set: normal exception switches process via predefined pointer; access-check alignment faults do not switch here
// (RULE_08) option set: user call switches process; return ends either kind
// (RULE_09) option clear: exceptions gate-style, user call gives illegal opcode
// (RULE_10) reset clears option and alignment bits
// (RULE_11) alignment bit 29 set: any byte address allowed for word, halfword
// (RULE_12) alignment bit clear: misaligned word or halfword raises alignment fault
// (RULE_13) software keeps status bits 30 and 31 zero
// (RULE_14) context block pointer register holds current block address
// (RULE_15) restart reads status, pc, sp from initial context section
// (RULE_16) switch writes status, pc, sp into control save area
// (RULE_17) stack limits come from the block's stack-bounds section
// (RULE_18) save r0-r10; with save and additional bits also r16-r23
// (RULE_19) block moves run in order until a null entry
// (RULE_20) extra registers saved only with bit 27 set and no block move
module cxu_core
   import cxu_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // status word, block pointer and exception view
   output logic [31:0] psw_out,
   output logic [31:0] cbp_out,
   output logic exc_valid,
   output logic [1:0] exception_type_code,
   output logic [3:0] exc_state_code,
   output logic [3:0] exc_rank
);
   typedef struct packed {
      logic [31:0] processor_status_word;
      logic [31:0] cbp;
      logic [31:0] predef;
      logic [31:0] rdata;
      logic wr_pend;
      logic [7:0] wr_addr;
      logic ev;
      logic [1:0] et;
      logic [3:0] code;
      logic [3:0] rank;
      logic [1:0] seq;
      logic [3:0] bm_count;
      logic bm_active;
      logic align_fault;
      logic ill_ucall;
      logic [4:0] save_regs;
      logic switched_exc;
      logic [31:0] pcb_addr;
   } cxu_state_t;

   cxu_state_t q, d;

   // classify one condition into type, rank and state code
   function automatic logic [9:0] cxu_classify(input logic [4:0] n);
      case (n)
         CXU_N_GATE_VEC: cxu_classify = {CXU_ET_NORMAL, 4'h1, 4'h6}; // RULE_01
         CXU_N_ILL_LEVEL: cxu_classify = {CXU_ET_NORMAL, 4'h3, 4'h7}; // RULE_01
         CXU_N_BKPT: cxu_classify = {CXU_ET_NORMAL, 4'h4, 4'he}; // RULE_01
         CXU_N_PRIV_OP: cxu_classify = {CXU_ET_NORMAL, 4'h5, 4'ha}; // RULE_01
         CXU_N_ILL_OP: cxu_classify = {CXU_ET_NORMAL, 4'h6, 4'h2}; // RULE_01
         CXU_N_RSV_OP: cxu_classify = {CXU_ET_NORMAL, 4'h7, 4'h3}; // RULE_01
         CXU_N_INV_DESC: cxu_classify = {CXU_ET_NORMAL, 4'h8, 4'h5}; // RULE_02
         CXU_N_RSV_DT: cxu_classify = {CXU_ET_NORMAL, 4'h9, 4'h8}; // RULE_02
         CXU_N_PRIV_REG: cxu_classify = {CXU_ET_NORMAL, 4'ha, 4'hf}; // RULE_02
         CXU_N_ZDIV: cxu_classify = {CXU_ET_NORMAL, 4'hb, 4'h0}; // RULE_02
         CXU_N_EXT_MEM: cxu_classify = {CXU_ET_NORMAL, 4'hd, 4'h5}; // RULE_02
         CXU_N_TRACE: cxu_classify = {CXU_ET_NORMAL, 4'he, 4'h1}; // RULE_02
         CXU_N_OVF: cxu_classify = {CXU_ET_NORMAL, 4'hf, 4'h9}; // RULE_02
         CXU_S_BOUND: cxu_classify = {CXU_ET_STACK, 4'h0, 4'h0}; // RULE_03
         CXU_S_FAULT: cxu_classify = {CXU_ET_STACK, 4'h1, 4'h1}; // RULE_03
         CXU_S_IID: cxu_classify = {CXU_ET_STACK, 4'h3, 4'h3}; // RULE_03
         CXU_P_OLD: cxu_classify = {CXU_ET_PROCESS, 4'h0, 4'h0}; // RULE_04
         CXU_P_GATE: cxu_classify = {CXU_ET_PROCESS, 4'h1, 4'h1}; // RULE_04
         CXU_P_NEW: cxu_classify = {CXU_ET_PROCESS, 4'h4, 4'h4}; // RULE_04
         CXU_R_OLD: cxu_classify = {CXU_ET_RESET, 4'h0, 4'h0}; // RULE_05
         CXU_R_SYSDATA: cxu_classify = {CXU_ET_RESET, 4'h1, 4'h1}; // RULE_05
         CXU_R_ISTK: cxu_classify = {CXU_ET_RESET, 4'h2, 4'h2}; // RULE_05
         CXU_R_EXT: cxu_classify = {CXU_ET_RESET, 4'h3, 4'h3}; // RULE_05
         CXU_R_NEW: cxu_classify = {CXU_ET_RESET, 4'h4, 4'h4}; // RULE_05
         CXU_R_GATE_VEC: cxu_classify = {CXU_ET_RESET, 4'h6, 4'h6}; // RULE_05
         // alignment fault reported as a normal exception, invalid descriptor rank
         CXU_N_ALIGN: cxu_classify = {CXU_ET_NORMAL, 4'h8, 4'h5};
         default: cxu_classify = 10'h000;
      endcase
   endfunction

   // true for conditions that clear the flags
   function automatic logic cxu_clears_flags(input logic [4:0] n);
      cxu_clears_flags = (n == CXU_N_INV_DESC) || (n == CXU_N_RSV_DT) || (n == CXU_N_ZDIV);
   endfunction

   // address of one section of a context block
   function automatic logic [31:0] cxu_section(input logic [31:0] base, input logic [31:0] off);
      cxu_section = base + off;
   endfunction

   // misaligned word or halfword access
   function automatic logic cxu_misaligned(input logic [1:0] a, input logic [1:0] sz);
      cxu_misaligned = (sz == 2'h2 && a != 2'h0) || (sz == 2'h1 && a[0]);
   endfunction

   logic addr_ok;
   logic [9:0] cls;
   logic [4:0] cnum;
   logic normal;

   assign addr_ok = hsel && htrans[1] && hready;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q.rdata;
   assign psw_out = q.processor_status_word;
   assign cbp_out = q.cbp;
   assign exc_valid = q.ev;
   assign exception_type_code = q.et;
   assign exc_state_code = q.code;
   assign exc_rank = q.rank;

   always_comb begin
      d = q;
      cnum = hwdata[4:0];
      cls = cxu_classify(cnum);
      normal = cls[9:8] == CXU_ET_NORMAL;
      d.ev = 1'b0;
      d.wr_pend = addr_ok && hwrite;
      d.wr_addr = haddr;
      ////////////////////////////////////////////////////////////////////
      // read data, latched at the address phase
      if (addr_ok && !hwrite) begin
         case ({haddr[7:2], 2'b00})
            CXU_A_PSW: d.rdata = q.processor_status_word;
            CXU_A_CBP: d.rdata = q.cbp; // RULE_14
            CXU_A_EXC: d.rdata = {16'h0000, q.rank, 2'b00, q.et, 4'h0, q.code};
            CXU_A_SEQ: d.rdata = {q.pcb_addr[15:0], 1'b0, q.switched_exc, q.save_regs,
                                  q.ill_ucall, q.align_fault, q.bm_active, q.bm_count, q.seq};
            CXU_A_PREDEF: d.rdata = q.predef;
            default: d.rdata = 32'h0000_0000;
         endcase
      end
      ////////////////////////////////////////////////////////////////////
      // write data phase
      if (q.wr_pend) begin
         case ({q.wr_addr[7:2], 2'b00})
            CXU_A_PSW: d.processor_status_word = hwdata & CXU_PSW_WMASK; // RULE_13
            CXU_A_CBP: d.cbp = hwdata; // RULE_14
            CXU_A_PREDEF: d.predef = hwdata;
            CXU_A_COND: begin
               d.ev = 1'b1;
               d.et = cls[9:8];
               d.rank = cls[7:4];
               d.code = cls[3:0];
               if (cxu_clears_flags(cnum)) begin
                  d.processor_status_word = q.processor_status_word & ~CXU_FLAG_MASK; // RULE_06
               end
               if (normal) begin
                  d.switched_exc = q.processor_status_word[CXU_PSW_EXUC];
                  if (q.processor_status_word[CXU_PSW_EXUC]) begin
                     d.seq = CXU_SEQ_SWITCH; // RULE_07
                     d.cbp = q.predef; // RULE_07
                  end else begin
                     d.seq = CXU_SEQ_GATE; // RULE_09
                  end
               end
            end
            CXU_A_ACCESS: begin
               // access check: bits 1:0 address, bits 3:2 size
               if (!q.processor_status_word[CXU_PSW_EA] && cxu_misaligned(hwdata[1:0], hwdata[3:2])) begin
                  d.align_fault = 1'b1; // RULE_12
                  d.ev = 1'b1;
                  d.et = CXU_ET_NORMAL;
                  d.rank = cls[7:4];
                  d.code = cls[3:0];
                  {d.et, d.rank, d.code} = cxu_classify(CXU_N_ALIGN);
               end else begin
                  d.align_fault = 1'b0; // RULE_11
               end
            end
            CXU_A_CMD: begin
               case (hwdata[2:0])
                  CXU_CMD_UCALL: begin
                     if (q.processor_status_word[CXU_PSW_EXUC]) begin
                        d.seq = CXU_SEQ_SWITCH; // RULE_08
                        d.ill_ucall = 1'b0;
                     end else begin
                        d.ill_ucall = 1'b1; // RULE_09
                        d.ev = 1'b1;
                        {d.et, d.rank, d.code} = cxu_classify(CXU_N_ILL_OP);
                     end
                  end
                  CXU_CMD_RET: begin
                     // return ends either a user-called or an exception switch
                     if (q.processor_status_word[CXU_PSW_EXUC]) begin
                        d.seq = CXU_SEQ_IDLE; // RULE_08
                        d.switched_exc = 1'b0;
                     end
                  end
                  CXU_CMD_RESTART: d.seq = CXU_SEQ_RESTART; // RULE_15
                  CXU_CMD_BMOVE: begin
                     d.bm_active = 1'b1; // RULE_19
                     d.bm_count = q.bm_count + 4'h1;
                  end
                  CXU_CMD_BMNULL: d.bm_active = 1'b0; // RULE_19
                  default: d.seq = q.seq;
               endcase
            end
            default: d.seq = q.seq;
         endcase
      end
      ////////////////////////////////////////////////////////////////////
      // section pointer follows a switch, restart or idle sequence that has just started
      if (d.seq != q.seq) begin
         case (d.seq)
            CXU_SEQ_SWITCH: d.pcb_addr = cxu_section(d.cbp, CXU_PCB_SAVE); // RULE_16
            CXU_SEQ_RESTART: d.pcb_addr = cxu_section(d.cbp, CXU_PCB_INIT); // RULE_15
            // a resumed process reloads its stack limits first
            CXU_SEQ_IDLE: d.pcb_addr = cxu_section(d.cbp, CXU_PCB_BOUNDS); // RULE_17
            default: d.pcb_addr = q.pcb_addr;
         endcase
      end
      ////////////////////////////////////////////////////////////////////
      // register save plan for the outgoing process
      d.save_regs = {q.processor_status_word[CXU_PSW_AR] && !q.bm_active, 4'hb}; // RULE_18 RULE_20
      if (!rst_n) begin
         d = '0;
         d.processor_status_word = CXU_PSW_RESET; // RULE_10
         d.cbp = CXU_PREDEF_CBP;
         d.predef = CXU_PREDEF_CBP;
         d.seq = CXU_SEQ_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end
endmodule
`default_nettype wire

// *** sim/cxu_core_asserts.sv ***
// checker: classification and status-word relations at the unit's ports
`default_nettype none
module cxu_core_asserts
   import cxu_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bus
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   // status and event
   input wire logic [31:0] psw_out,
   input wire logic exc_valid,
   input wire logic [1:0] exception_type_code,
   input wire logic [3:0] exc_state_code,
   input wire logic [3:0] exc_rank
);
   logic aw_q;
   logic [7:0] aa_q;
   logic cw;
   logic acc;
   logic mis;
   ////////////////////////////////////////////////////////////////////////////////
   // data-phase write tracker
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         aw_q <= 1'b0;
         aa_q <= 8'h00;
      end else if (hready) begin
         aw_q <= hsel && htrans[1] && hwrite;
         aa_q <= haddr;
      end
   end
   assign cw = aw_q && aa_q == CXU_A_COND;
   assign acc = aw_q && aa_q == CXU_A_ACCESS;
   assign mis = hwdata[3:2] == 2'h2 ? hwdata[1:0] != 2'h0 : hwdata[3:2] == 2'h1 && hwdata[0];
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   gate_vec_class_a:
      assert property (cw && hwdata == 32'd0 |=> exc_valid && exception_type_code == 2'h3
         && exc_rank == 4'h1 && exc_state_code == 4'h6) else $error("gate vector class wrong");
   zero_div_class_a:
      assert property (cw && hwdata == 32'd9 |=> exc_valid && exception_type_code == 2'h3
         && exc_rank == 4'hb && exc_state_code == 4'h0) else $error("zero divide class wrong");
   stack_class_a:
      assert property (cw && hwdata inside {[13:15]} |=> exc_valid && exception_type_code == 2'h2
         && exc_rank == exc_state_code) else $error("stack class wrong");
   process_class_a:
      assert property (cw && hwdata inside {[16:18]} |=> exc_valid && exception_type_code == 2'h1
         && exc_rank == exc_state_code) else $error("process class wrong");
   reset_class_a:
      assert property (cw && hwdata inside {[19:24]} |=> exc_valid && exception_type_code == 2'h0
         && exc_rank == exc_state_code) else $error("reset class wrong");
   flag_clear_a:
      assert property (cw && hwdata inside {6, 7, 9} |-> ##[1:2] (psw_out & CXU_FLAG_MASK) == 0)
         else $error("flags not cleared");
   reset_bits_a:
      assert property ($rose(rst_n) |-> psw_out[29:27] == 3'h0) else $error("option bits set");
   psw_top_zero_a:
      assert property (psw_out[31:30] == 2'h0) else $error("status top bits set");
   misalign_fault_a:
      assert property (acc && mis && !psw_out[CXU_PSW_EA] |=> exc_valid && exc_rank == 4'h8
         && exc_state_code == 4'h5) else $error("no alignment fault");
   free_align_a:
      assert property (acc && psw_out[CXU_PSW_EA] |=> !exc_valid) else $error("alignment fault");
   ucall_illegal_a:
      assert property (aw_q && aa_q == CXU_A_CMD && hwdata[2:0] == CXU_CMD_UCALL
         && !psw_out[CXU_PSW_EXUC] |=> exc_valid && exc_rank == 4'h6 && exc_state_code == 4'h2)
         else $error("user call not refused");
   cover property (exc_valid && exception_type_code == 2'h0);
   cover property (acc && mis && !psw_out[CXU_PSW_EA]);
   cover property (psw_out[CXU_PSW_EXUC]);
endmodule
`default_nettype wire

// *** sim/cxu_host.sv ***
// partner: bus master standing in for the processor side
`default_nettype none
module cxu_host (
   // clock
   input wire logic clk,
   // ahb-lite master
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   // wait ran out
   output logic hung
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      hung = 1'b0;
   end
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) hung <= 1'b1;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask
endmodule
`default_nettype wire

// *** sim/test_cpu_exception_and_context_control.sv ***
// testbench: register-bus scenarios for the exception and context unit
`default_nettype none
module test_cpu_exception_and_context_control;
   timeunit 1ns;
   timeprecision 1ps;
   import cxu_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic rd_ph = 1'b0;
   logic hsel, hwrite, hready, hreadyout, hresp, exc_valid, hung;
   logic [1:0] htrans, et;
   logic [2:0] hsize;
   logic [7:0] haddr;
   logic [3:0] code, rank;
   logic [31:0] hwdata, hrdata, psw_out, cbp_out, v;
   logic [63:0] rd_exp[$];
   logic [11:0] ex_exp[$];
   logic [11:0] cls [26] = '{12'h361, 12'h373, 12'h3e4, 12'h3a5, 12'h326, 12'h337, 12'h358,
      12'h389, 12'h3fa, 12'h30b, 12'h35d, 12'h31e, 12'h39f, 12'h200, 12'h211, 12'h233, 12'h100,
      12'h111, 12'h144, 12'h000, 12'h011, 12'h022, 12'h033, 12'h044, 12'h066, 12'h358};
   int fl[4] = '{6, 7, 9, 8};
   int failures = 0;
   int checked = 0;
   int seed = 32'hb65e;
   int n;
   assign hready = hreadyout;
   always #2 clk = ~clk;
   cxu_core dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .psw_out(psw_out), .cbp_out(cbp_out),
      .exc_valid(exc_valid), .exception_type_code(et), .exc_state_code(code), .exc_rank(rank));
   cxu_host host_u (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hung(hung));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic fail(input string m);
      failures++;
      $display("unexpected at %0t: %s", $time, m);
   endtask
   task automatic cmp_rd(input logic [63:0] e);
      checked++;
      if ((hrdata & e[63:32]) !== e[31:0] || hresp !== 1'b0) fail("read data");
   endtask
   task automatic cmp_ex(input logic [11:0] e);
      checked++;
      if ({2'h0, et, code, rank} !== e) fail("event class");
   endtask
   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) fail("port value");
   endtask
   task automatic close_out;
      $display("mismatches %0d comparisons %0d", failures, checked);
      if (failures == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      rd_exp.push_back({m, e});
      host_u.xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdm(a, e, 32'hffff_ffff);
   endtask
   task automatic cond(input int k);
      ex_exp.push_back(cls[k]);
      wr(CXU_A_COND, 32'(k));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // result watcher
   always @(posedge clk) begin
      if (hung === 1'b1) begin
         fail("bus wait ran out");
         close_out();
      end
      if (rd_ph) begin
         if (rd_exp.size() == 0) fail("stray read");
         else cmp_rd(rd_exp.pop_front());
      end
      if (rst_n && exc_valid === 1'b1) begin
         if (ex_exp.size() == 0) fail("stray event");
         else cmp_ex(ex_exp.pop_front());
      end
      rd_ph = rst_n && hsel && htrans[1] && !hwrite && hready;
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(CXU_A_PSW, 32'h0000_0000);
      for (int k = 0; k < 26; k++) cond(k);
      repeat (6) begin
         n = $unsigned($random(seed)) % 26;
         cond(n);
      end
      rd(CXU_A_EXC, {16'h0000, cls[n][3:0], 2'h0, cls[n][9:8], 4'h0, cls[n][7:4]});
      v = $random(seed) & 32'hffff_fffc;
      wr(CXU_A_CBP, v);
      rd(CXU_A_CBP, v);
      cmp_word(cbp_out, v);
      foreach (fl[i]) begin
         wr(CXU_A_PSW, CXU_FLAG_MASK);
         cond(fl[i]);
         rdm(CXU_A_PSW, fl[i] == 8 ? CXU_FLAG_MASK : 32'h0000_0000, CXU_FLAG_MASK);
      end
      for (int ea = 0; ea < 2; ea++) begin
         wr(CXU_A_PSW, ea ? 32'h2000_0000 : 32'h0000_0000);
         for (int s = 1; s < 3; s++) begin
            for (int a = 0; a < 4; a++) begin
               if (ea == 0 && (s == 2 ? a != 0 : a[0])) ex_exp.push_back(cls[25]);
               wr(CXU_A_ACCESS, 32'(s * 4 + a));
            end
         end
      end
      wr(CXU_A_PSW, 32'h0000_0000);
      ex_exp.push_back(cls[4]);
      wr(CXU_A_CMD, 32'(CXU_CMD_UCALL));
      wr(CXU_A_PSW, 32'h1000_0000);
      wr(CXU_A_CMD, 32'(CXU_CMD_UCALL));
      rdm(CXU_A_SEQ, {v[15:0] + 16'h000c, 16'h0002}, 32'hffff_0003);
      wr(CXU_A_CMD, 32'(CXU_CMD_RET));
      rdm(CXU_A_SEQ, {v[15:0] + 16'h0018, 16'h0000}, 32'hffff_0003);
      wr(CXU_A_CMD, 32'(CXU_CMD_RESTART));
      rdm(CXU_A_SEQ, {v[15:0], 16'h0003}, 32'hffff_0003);
      wr(CXU_A_CMD, 32'(CXU_CMD_BMOVE));
      rdm(CXU_A_SEQ, 32'h0000_0044, 32'h0000_007c);
      wr(CXU_A_CMD, 32'(CXU_CMD_BMNULL));
      rdm(CXU_A_SEQ, 32'h0000_0004, 32'h0000_007c);
      wr(CXU_A_PREDEF, 32'h0000_4000);
      cond(0);
      rd(CXU_A_CBP, 32'h0000_4000);
      cmp_word(cbp_out, 32'h0000_4000);
      wr(CXU_A_PSW, 32'hffff_ffff);
      rdm(CXU_A_PSW, 32'h3000_0000, 32'hf000_0000);
      rd(8'h20, 32'h0000_0000);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd(CXU_A_PSW, 32'h0000_0000);
      repeat (4) @(posedge clk);
      if (rd_exp.size() != 0 || ex_exp.size() != 0) fail("result missing");
      close_out();
   end
endmodule
bind cxu_core cxu_core_asserts chk_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .psw_out(psw_out),
   .exc_valid(exc_valid), .exception_type_code(exception_type_code),
   .exc_state_code(exc_state_code), .exc_rank(exc_rank));
`default_nettype wire
